// ### ipe_top.sv
// Interrupt priority expander: peripheral groups to CPU lines, then fixed CPU arbitration.
// Assumes peripheral requests are synchronous one-cycle-or-longer levels on ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
module ipe_top
  import ipe_pkg::*;
(
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          rstn_in,
  // Register port
  input  wire ipe_bus_t                      bus_in,
  output var  logic [15:0]                   rdata_out,
  // Request sources
  input  wire logic [IPE_NGROUP*IPE_NSRC-1:0] periph_req_in,
  input  wire logic [IPE_NLINE-1:0]          line_req_in,
  input  wire logic                          reset_req_in,
  input  wire logic                          nmi_req_in,
  // Core side
  input  wire logic                          accept_in,
  output var  ipe_vec_t                      vec_out,
  output var  logic                          irq_out
);

  // ==========================================================
  // Register state
  logic [15:0]            line_en_reg, line_en_next;
  logic                   exp_on_reg, exp_on_next;
  logic [IPE_NGROUP-1:0]  grp_armed_reg, grp_armed_next;
  logic [IPE_NSRC-1:0]    src_en_reg [IPE_NGROUP], src_en_next [IPE_NGROUP];
  logic [IPE_NSRC-1:0]    src_pnd_reg [IPE_NGROUP], src_pnd_next [IPE_NGROUP];
  logic [IPE_NST-1:0]     st_reg, st_next, msk_reg, msk_next;
  logic [15:0]            rdata_reg, rdata_next;
  ipe_vec_t               vec_reg, vec_next;
  logic                   irq_reg, irq_next;

  logic [IPE_NGROUP-1:0]  grp_req;
  logic [2:0]             grp_top [IPE_NGROUP];
  logic [IPE_NLINE-1:0]   line_pnd;
  logic [5:0]             sel;

  // ==========================================================
  // Group expansion
  always_comb begin
    for (int g = 0; g < IPE_NGROUP; g++) begin
      logic [IPE_NSRC-1:0] act;
      act = src_pnd_reg[g] & src_en_reg[g];
      grp_req[g] = (|act) & grp_armed_reg[g];
      grp_top[g] = 3'h0;
      for (int s = IPE_NSRC-1; s >= 0; s--) begin
        if (act[s]) begin
          grp_top[g] = 3'(s);
        end
      end
    end
  end

  always_comb begin
    line_pnd = line_req_in;
    if (exp_on_reg) begin
      line_pnd[IPE_NGROUP-1:0] = grp_req;
    end
    line_pnd = line_pnd & line_en_reg;
  end

  // ==========================================================
  // CPU-level arbitration
  always_comb begin
    vec_next = '0;
    if (reset_req_in) begin
      vec_next.valid = 1'b1;
      vec_next.rank  = IPE_RANK_RESET;
    end else if (nmi_req_in) begin
      vec_next.valid = 1'b1;
      vec_next.rank  = IPE_RANK_NMI;
    end else begin
      for (int l = IPE_NLINE-1; l >= 0; l--) begin
        if (line_pnd[l]) begin
          vec_next.valid = 1'b1;
          vec_next.rank  = (l == IPE_BIT_LOG) ? IPE_RANK_LOG :
                           (l == IPE_BIT_OS)  ? IPE_RANK_OS :
                           5'(IPE_RANK_LINE1 + 5'(l));
          vec_next.group = (exp_on_reg && l < IPE_NGROUP) ? 4'(l + 1) : 4'h0;
          vec_next.source = (exp_on_reg && l < IPE_NGROUP) ? grp_top[l] : 3'h0;
        end
      end
    end
  end

  // ==========================================================
  // Registers, pending flags and interrupt status
  always_comb begin
    logic [3:0] gi;
    logic       acc_grp;
    gi = vec_reg.group - 4'h1;
    acc_grp = accept_in && vec_reg.valid && (vec_reg.group != 4'h0);
    sel = bus_in.addr;
    line_en_next   = line_en_reg;
    exp_on_next    = exp_on_reg;
    grp_armed_next = grp_armed_reg;
    msk_next       = msk_reg;
    st_next        = st_reg;
    rdata_next     = 16'h0000;
    for (int g = 0; g < IPE_NGROUP; g++) begin
      src_en_next[g]  = src_en_reg[g];
      src_pnd_next[g] = src_pnd_reg[g];
    end
    if (bus_in.wr) begin
      case (sel)
        IPE_A_LINE_EN: line_en_next = bus_in.wdata;
        IPE_A_CTRL:    exp_on_next  = bus_in.wdata[0];
        IPE_A_GRP_ACK: grp_armed_next = grp_armed_reg | bus_in.wdata[IPE_NGROUP-1:0];
        IPE_A_STATUS:  st_next = st_reg & ~bus_in.wdata[IPE_NST-1:0];
        IPE_A_MASK:    msk_next = bus_in.wdata[IPE_NST-1:0];
        default: begin
          for (int g = 0; g < IPE_NGROUP; g++) begin
            if (sel == IPE_A_SRC_EN0 + 6'(g)) begin
              src_en_next[g] = bus_in.wdata[IPE_NSRC-1:0];
            end
          end
        end
      endcase
    end
    if (acc_grp) begin
      src_pnd_next[gi][vec_reg.source] = 1'b0;
      grp_armed_next[gi] = 1'b0;
    end
    if (accept_in && vec_reg.valid) begin
      st_next[IPE_ST_ACCEPT] = 1'b1;
    end
    for (int g = 0; g < IPE_NGROUP; g++) begin
      if ((src_pnd_reg[g] & periph_req_in[g*IPE_NSRC +: IPE_NSRC]) != '0) begin
        st_next[IPE_ST_OVR] = 1'b1;
      end
      src_pnd_next[g] = src_pnd_next[g] | periph_req_in[g*IPE_NSRC +: IPE_NSRC];
    end
    if (bus_in.rd) begin
      case (sel)
        IPE_A_LINE_EN:  rdata_next = line_en_reg;
        IPE_A_CTRL:     rdata_next = {15'h0000, exp_on_reg};
        IPE_A_GRP_ACK:  rdata_next = {4'h0, grp_armed_reg};
        IPE_A_STATUS:   rdata_next = {14'h0000, st_reg};
        IPE_A_MASK:     rdata_next = {14'h0000, msk_reg};
        IPE_A_LINE_PND: rdata_next = line_pnd;
        default: begin
          for (int g = 0; g < IPE_NGROUP; g++) begin
            if (sel == IPE_A_SRC_EN0 + 6'(g)) begin
              rdata_next = {8'h00, src_en_reg[g]};
            end
            if (sel == IPE_A_SRC_PND0 + 6'(g)) begin
              rdata_next = {8'h00, src_pnd_reg[g]};
            end
          end
        end
      endcase
    end
    irq_next = |(st_next & msk_next);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_en_reg   <= 16'h0000;
      exp_on_reg    <= 1'b0;
      grp_armed_reg <= 12'hfff;
      st_reg        <= 2'h0;
      msk_reg       <= 2'h0;
      rdata_reg     <= 16'h0000;
      vec_reg       <= '0;
      irq_reg       <= 1'b0;
      for (int g = 0; g < IPE_NGROUP; g++) begin
        src_en_reg[g]  <= 8'h00;
        src_pnd_reg[g] <= 8'h00;
      end
    end else begin
      line_en_reg   <= line_en_next;
      exp_on_reg    <= exp_on_next;
      grp_armed_reg <= grp_armed_next;
      st_reg        <= st_next;
      msk_reg       <= msk_next;
      rdata_reg     <= rdata_next;
      vec_reg       <= vec_next;
      irq_reg       <= irq_next;
      for (int g = 0; g < IPE_NGROUP; g++) begin
        src_en_reg[g]  <= src_en_next[g];
        src_pnd_reg[g] <= src_pnd_next[g];
      end
    end
  end

  assign rdata_out = rdata_reg;
  assign vec_out   = vec_reg;
  assign irq_out   = irq_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  reset_wins_a: assert property (reset_req_in |=> vec_out.rank == IPE_RANK_RESET)
    else $error("reset request did not win");
  nmi_over_line_a: assert property (!reset_req_in && nmi_req_in |=> vec_out.rank == IPE_RANK_NMI)
    else $error("nmi did not win over lines");
  // Ranks 5 to 20 map onto enable bits 0 to 15 in order
  mask_gates_a: assert property (vec_next.valid && vec_next.rank >= IPE_RANK_LINE1 |->
    line_en_reg[4'(vec_next.rank - IPE_RANK_LINE1)])
    else $error("disabled line reached core");
  line_en_wr_a: assert property (bus_in.wr && bus_in.addr == IPE_A_LINE_EN |=>
    line_en_reg == $past(bus_in.wdata))
    else $error("line enable not written");
  group_route_a: assert property (vec_out.group != 4'h0 |->
    vec_out.rank == 5'(IPE_RANK_LINE1 + vec_out.group - 5'h1))
    else $error("group on wrong line");
  src_enabled_a: assert property (vec_next.group != 4'h0 |->
    src_en_reg[vec_next.group - 4'h1][vec_next.source])
    else $error("disabled source reported");
  first_src_a: assert property (vec_next.group != 4'h0 && vec_next.source != 3'h0 |->
    (src_pnd_reg[vec_next.group - 4'h1] & src_en_reg[vec_next.group - 4'h1]
      & ((8'h01 << vec_next.source) - 8'h01)) == 8'h00)
    else $error("lower source beat higher one");
  ack_clears_a: assert property (accept_in && vec_out.group != 4'h0 && !periph_req_in[0] |=>
    !grp_armed_reg[$past(vec_out.group) - 4'h1])
    else $error("accept did not disarm group");
  irq_follows_a: assert property (irq_out == |(st_reg & msk_reg))
    else $error("interrupt output mismatch");

  // Group accept on the core link
  sequence grp_accept_s;
    accept_in && vec_out.group != 4'h0;
  endsequence
  // One edge later only the taken flag has dropped; new requests still land
  sequence only_taken_clr_s;
    src_pnd_reg[$past(vec_out.group) - 4'h1] ==
      (($past(src_pnd_reg[vec_out.group - 4'h1]) & ~(8'h01 << $past(vec_out.source)))
      | $past(periph_req_in[(int'(vec_out.group) - 1) * IPE_NSRC +: IPE_NSRC]));
  endsequence
  only_src_clr_a: assert property (grp_accept_s |=> only_taken_clr_s)
    else $error("accept changed other pending flags");
  accept_irq_a: assert property (accept_in && vec_out.valid && msk_reg[IPE_ST_ACCEPT]
    && !(bus_in.wr && bus_in.addr == IPE_A_MASK) |=> irq_out)
    else $error("accept did not raise interrupt");

endmodule
`default_nettype wire

// ### ipe_pkg.sv
// Constants and carrier types for the interrupt priority expander.
// Assumes a single clock domain and an active-low asynchronous reset.
// How it works
// - Fixed rank: reset, reserved, NMI, lines, log, OS
// - Maskable lines pass only when enabled
// - Sixteen-bit line enable mask, one bit each
// - Expander drives lines 1 to 12 when on
// - Each group has eight-bit source enable
// - Inside a group position 1 wins
// - Group x feeds CPU line x
package ipe_pkg;

  // ==========================================================
  // Sizes
  localparam int IPE_NGROUP = 12;
  localparam int IPE_NSRC   = 8;
  localparam int IPE_NLINE  = 16;

  // ==========================================================
  // Register map (word addresses on the plain port)
  localparam logic [5:0]  IPE_A_LINE_EN  = 6'h00;
  localparam logic [5:0]  IPE_A_CTRL     = 6'h01;
  localparam logic [5:0]  IPE_A_GRP_ACK  = 6'h02;
  localparam logic [5:0]  IPE_A_STATUS   = 6'h03;
  localparam logic [5:0]  IPE_A_MASK     = 6'h04;
  localparam logic [5:0]  IPE_A_LINE_PND = 6'h05;
  localparam logic [5:0]  IPE_A_SRC_EN0  = 6'h10;
  localparam logic [5:0]  IPE_A_SRC_PND0 = 6'h20;
  localparam logic [5:0]  IPE_A_GRP_MSK  = 6'h30;
  localparam logic [15:0] IPE_ACK_ALL    = 16'hffff;

  // Status bits: 0 accept seen, 1 request dropped while pending
  localparam int IPE_ST_ACCEPT = 0;
  localparam int IPE_ST_OVR    = 1;
  localparam int IPE_NST       = 2;

  // ==========================================================
  // Arbitration ranks, lower is higher priority
  localparam logic [4:0] IPE_RANK_RESET = 5'h01;
  localparam logic [4:0] IPE_RANK_RSVD  = 5'h02;
  localparam logic [4:0] IPE_RANK_NMI   = 5'h03;
  localparam logic [4:0] IPE_RANK_LINE1 = 5'h05;
  localparam logic [4:0] IPE_RANK_LOG   = 5'h13;
  localparam logic [4:0] IPE_RANK_OS    = 5'h14;
  localparam logic [4:0] IPE_RANK_NONE  = 5'h00;
  localparam int IPE_BIT_LOG = 14;
  localparam int IPE_BIT_OS  = 15;

  typedef struct packed {
    logic       valid;
    logic [4:0] rank;
    logic [3:0] group;
    logic [2:0] source;
  } ipe_vec_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } ipe_bus_t;

endpackage

// ### ipe_core_model.sv
// Behavioural CPU core that takes vectors from the interrupt priority expander.
// Assumes the expander's vector is registered on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ipe_core_model
  import ipe_pkg::*;
#(
  parameter int WAIT_CYC = 2
) (
  // Clock and reset
  input  wire logic     clk_in,
  input  wire logic     rstn_in,
  // Global mask flag of the core, high blocks all service, reset and NMI vectors included
  input  wire logic     gmask_in,
  // Expander link
  input  wire ipe_vec_t vec_in,
  output var  logic     accept_out,
  output var  ipe_vec_t taken_out,
  output var  int       count_out
);
  int cnt;
  // ==========================================================
  // Acceptance
  // The stale vector after an accept counts once only, so WAIT_CYC of 1 or more never takes it twice
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 0;
      accept_out <= 1'b0;
      taken_out <= '0;
      count_out <= 0;
    end else if (accept_out) begin
      accept_out <= 1'b0;
      cnt <= 0;
      taken_out <= vec_in;
      count_out <= count_out + 1;
    end else if (vec_in.valid && !gmask_in) begin
      cnt <= (cnt == WAIT_CYC) ? 0 : cnt + 1;
      accept_out <= (cnt == WAIT_CYC);
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ### ipe_top_tb.sv
// Self-checking bench for the interrupt priority expander.
// Assumes ipe_pkg and ipe_core_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module ipe_top_tb
  import ipe_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in;
  ipe_bus_t    bus;
  logic [15:0] rdata;
  logic [95:0] preq;
  logic [15:0] lreq;
  logic        rreq, nreq, acc, irq, gmask;
  ipe_vec_t    vec, taken;
  int          ntaken, err_count = 0, n_checks = 0, cyc = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  ipe_top u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
    .periph_req_in(preq), .line_req_in(lreq), .reset_req_in(rreq), .nmi_req_in(nreq),
    .accept_in(acc), .vec_out(vec), .irq_out(irq));
  ipe_core_model #(.WAIT_CYC(2)) u_core (.clk_in(ref_clk_in), .rstn_in(rstn_in), .gmask_in(gmask),
    .vec_in(vec), .accept_out(acc), .taken_out(taken), .count_out(ntaken));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_in);
    bus <= '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk_in);
    bus <= '0;
    #1 chk(rdata, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask
  // Bounded wait: a lost accept shows up as a stale taken vector
  task automatic wait_taken(input int n);
    for (int k = 0; k < 40 && ntaken < n; k++) @(posedge ref_clk_in);
    #1;
  endtask
  function automatic logic [15:0] ev(input logic [4:0] r, input logic [3:0] g, input logic [2:0] s);
    return {3'h0, 1'b1, r, g, s};
  endfunction
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    rstn_in = 1'b0;
    bus = '0;
    preq = '0;
    lreq = '0;
    rreq = 1'b0;
    nreq = 1'b0;
    gmask = 1'b1;
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    #1 chk(16'(vec), 16'h0000);
    rd(IPE_A_LINE_EN, 16'h0000);
    rd(IPE_A_GRP_MSK, 16'h0000);
    wr(IPE_A_LINE_EN, 16'hffff);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_in);
      lreq <= 16'h0001 << i;
      settle();
      chk(16'(vec), ev(5'(5 + i), 4'h0, 3'h0));
      wr(IPE_A_LINE_EN, ~(16'h0001 << i));
      settle();
      chk(16'(vec), 16'h0000);
      wr(IPE_A_LINE_EN, 16'hffff);
    end
    @(posedge ref_clk_in);
    lreq <= 16'hc006;
    settle();
    chk(16'(vec), ev(5'h06, 4'h0, 3'h0));
    @(posedge ref_clk_in) nreq <= 1'b1;
    settle();
    chk(16'(vec), ev(IPE_RANK_NMI, 4'h0, 3'h0));
    @(posedge ref_clk_in) rreq <= 1'b1;
    settle();
    chk(16'(vec), ev(IPE_RANK_RESET, 4'h0, 3'h0));
    @(posedge ref_clk_in);
    {rreq, nreq, lreq} <= {2'b00, 16'h0001};
    wr(IPE_A_CTRL, 16'h0001);
    for (int g = 0; g < 12; g++) wr(IPE_A_SRC_EN0 + 6'(g), 16'h00ff);
    wr(IPE_A_SRC_EN0 + 6'h02, 16'h00fe);
    wr(IPE_A_MASK, 16'h0001);
    rd(IPE_A_CTRL, 16'h0001);
    chk(16'(vec), 16'h0000);
    // Group 2 sources 2 and 4, group 5 source 1, masked group 3 source 1
    @(posedge ref_clk_in);
    preq <= (96'h1 << 9) | (96'h1 << 11) | (96'h1 << 32) | (96'h1 << 16);
    @(posedge ref_clk_in);
    preq <= '0;
    settle();
    chk(16'(vec), ev(5'h06, 4'h2, 3'h1));
    rd(IPE_A_LINE_PND, 16'h0012);
    @(posedge ref_clk_in) gmask <= 1'b0;
    wait_taken(1);
    chk(16'(taken), ev(5'h06, 4'h2, 3'h1));
    wait_taken(2);
    chk(16'(taken), ev(5'h09, 4'h5, 3'h0));
    rd(IPE_A_SRC_PND0 + 6'h01, 16'h0008);
    rd(IPE_A_SRC_PND0 + 6'h02, 16'h0001);
    rd(IPE_A_GRP_ACK, 16'h0fed);
    repeat (3) settle();
    chk(16'(ntaken), 16'h0002);
    chk(16'(irq), 16'h0001);
    wr(IPE_A_GRP_ACK, IPE_ACK_ALL);
    wait_taken(3);
    chk(16'(taken), ev(5'h06, 4'h2, 3'h3));
    wr(IPE_A_MASK, 16'h0000);
    settle();
    chk(16'(irq), 16'h0000);
    wr(IPE_A_MASK, 16'h0001);
    wr(IPE_A_STATUS, 16'h0003);
    settle();
    chk(16'(irq), 16'h0000);
    // A second request on a still pending source raises the overrun status
    @(posedge ref_clk_in) preq <= 96'h1 << 16;
    @(posedge ref_clk_in) preq <= '0;
    rd(IPE_A_STATUS, 16'h0002);
    wr(IPE_A_MASK, 16'h0002);
    settle();
    chk(16'(irq), 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
